// [src/sac_defines.svh]
// Register map, field positions, reset values and counts of the ADC control.
// What this block does
// (R1) A conversion takes exactly 50 converter clock ticks from the start.
// (R2) Each of the 12 result bits takes two ticks; the rest is sampling.
// (R3) At the end the done flag is set and the result loaded together.
// (R4) The converter clock is system clock over 32, 16, 8 or 4 by a field.
// (R5) The done flag clears on a flag write with its bit zero or on start.
// (R6) Result bits 11..4 read as one byte, bits 3..0 as an upper nibble.
// (R7) A 4-bit field picks the input; 1011 is bandgap, 1111 supply/4.
// (R8) Firmware turns the bandgap off and leaves code 1111 for low current.
// (R9) A 2-bit field picks the reference: supply, 2.5V, 3V or 4V.
// (R10) Writing one to the start bit starts; hardware clears it at the end.
// (R11) Writing zero to the start bit clears it at once.
// (R12) Firmware keeps the converter clock below 1 MHz before a start.
// (R13) A set done flag with the interrupt enabled raises a request.
// (R14) The result registers hold until a later conversion replaces them.
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SAC_ADDR_OPTION 8'h94
`define SAC_ADDR_INTERRUPT_FLAG_REGISTER 8'h95
`define SAC_ADDR_DATA_LO 8'haa
`define SAC_ADDR_DATA_HI 8'hab
`define SAC_ADDR_CHAN 8'hb6
`define SAC_ADDR_AUXILIARY_CONTROL_THREE 8'hef
`define SAC_ADDR_AUXILIARY_CONTROL_ONE 8'hf8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SAC_DIV_HI 3
`define SAC_DIV_LO 2
`define SAC_FLAG_BIT 4
`define SAC_START_BIT 4
`define SAC_BG_BIT 2
`define SAC_REF_HI 1
`define SAC_REF_LO 0
`define SAC_CHAN_HI 3
`define SAC_CHAN_LO 0

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define SAC_CHAN_RESET 4'hf
`define SAC_DIV_RESET 2'h0
`define SAC_REF_RESET 2'h0
`define SAC_RES_RESET 12'h000
`define SAC_RES_MSB 12'h800
`define SAC_DIV_BY32 2'h0
`define SAC_DIV_BY16 2'h1
`define SAC_DIV_BY8 2'h2
`define SAC_LIM32 5'h1f
`define SAC_LIM16 5'h0f
`define SAC_LIM8 5'h07
`define SAC_LIM4 5'h03

// ----------------------------------------------------------------------
// Conversion timing in converter clock ticks
// ----------------------------------------------------------------------
`define SAC_CONV_TICKS 6'd50
`define SAC_BITS 4'd12
`define SAC_SAMPLE_TICKS 6'd26
`define SAC_TOP_BIT 4'hb

`endif

// [src/sac_pkg.sv]
// Types shared by the ADC control modules.
package sac_pkg;

  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_SAMPLE = 3'b010,
    SAC_CONVERT = 3'b100
  } sac_mode_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } sac_div_state_t;

  typedef struct packed {
    sac_mode_t mode;
    logic [5:0] ticks;
    logic phase;
    logic [3:0] bit_idx;
    logic [11:0] sar;
    logic hold;
    logic done;
  } sac_seq_state_t;

  typedef struct packed {
    logic [1:0] div_sel;
    logic flag;
    logic [3:0] chan;
    logic bg_en;
    logic [1:0] ref_sel;
    logic start;
    logic [11:0] result;
    logic [7:0] rdata;
    logic irq;
  } sac_top_state_t;

endpackage : sac_pkg

// [src/sac_clk_div.sv]
// Converter clock divider producing a one-cycle tick enable.
`timescale 1ns/10ps
`include "sac_defines.svh"

module sac_clk_div (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [1:0] div_sel,
  // Tick
  output logic tick
);

  sac_pkg::sac_div_state_t s_r;
  sac_pkg::sac_div_state_t s_nxt;
  logic [4:0] limit;

  always_comb begin
    case (div_sel) // see (R4)
      `SAC_DIV_BY32: limit = `SAC_LIM32;
      `SAC_DIV_BY16: limit = `SAC_LIM16;
      `SAC_DIV_BY8: limit = `SAC_LIM8;
      default: limit = `SAC_LIM4;
    endcase
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!run) begin
      s_nxt.cnt = 5'h00;
    end else if (s_r.cnt >= limit) begin
      s_nxt.cnt = 5'h00;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

  AST_DIV_BY4: assert property (@(posedge clk_sys) disable iff (reset) // see (R4)
    (tick && div_sel == 2'h3 ##1 (run && div_sel == 2'h3) [*4]) |-> tick)
    else $error("divide by four tick spacing wrong");

endmodule : sac_clk_div

// [src/sac_sar_seq.sv]
// Sample phase and successive approximation sequencer.
`timescale 1ns/10ps
`include "sac_defines.svh"

module sac_sar_seq (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  input wire logic compare_high,
  // Status and result
  output logic busy,
  output logic hold,
  output logic done,
  output logic [11:0] sar_code
);

  sac_pkg::sac_seq_state_t s_r;
  sac_pkg::sac_seq_state_t s_nxt;
  logic [5:0] ticks_inc;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    ticks_inc = s_r.ticks + 6'd1;
    if (start) begin
      s_nxt.mode = sac_pkg::SAC_SAMPLE;
      s_nxt.ticks = 6'd0;
      s_nxt.phase = 1'b0;
      s_nxt.sar = `SAC_RES_RESET;
      s_nxt.hold = 1'b1;
    end else if (abort) begin
      s_nxt.mode = sac_pkg::SAC_IDLE;
      s_nxt.hold = 1'b0;
    end else if (tick) begin
      case (s_r.mode)
        sac_pkg::SAC_SAMPLE: begin
          s_nxt.ticks = ticks_inc;
          if (ticks_inc == `SAC_SAMPLE_TICKS) begin // see (R2)
            s_nxt.mode = sac_pkg::SAC_CONVERT;
            s_nxt.hold = 1'b0;
            s_nxt.bit_idx = `SAC_TOP_BIT;
            s_nxt.sar = `SAC_RES_MSB;
          end
        end
        sac_pkg::SAC_CONVERT: begin
          s_nxt.ticks = ticks_inc;
          s_nxt.phase = ~s_r.phase; // see (R2)
          if (s_r.phase) begin
            s_nxt.sar[s_r.bit_idx] = compare_high;
            if (s_r.bit_idx != 4'h0) begin
              s_nxt.sar[s_r.bit_idx - 4'h1] = 1'b1;
              s_nxt.bit_idx = s_r.bit_idx - 4'h1;
            end
          end
          if (ticks_inc == `SAC_CONV_TICKS) begin // see (R1)
            s_nxt.mode = sac_pkg::SAC_IDLE;
            s_nxt.done = 1'b1;
          end
        end
        default: begin
          s_nxt.mode = sac_pkg::SAC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.mode <= sac_pkg::SAC_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = (s_r.mode != sac_pkg::SAC_IDLE);
  assign hold = s_r.hold;
  assign done = s_r.done;
  assign sar_code = s_r.sar;

  AST_FIFTY_TICKS: assert property (@(posedge clk_sys) disable iff (reset)
    done |-> $past(s_r.ticks) == `SAC_CONV_TICKS - 6'd1) // see (R1)
    else $error("conversion did not take fifty ticks");

  AST_PAIR_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    (s_r.mode == sac_pkg::SAC_CONVERT && tick && !s_r.phase && !start
     && !abort) |=> $stable(s_r.sar)) // see (R2)
    else $error("bit decided on first tick of a pair");

endmodule : sac_sar_seq

// [src/sac_top.sv]
// ADC conversion control: registers, clock divider and sequencer.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`include "sac_defines.svh"

module sac_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt
  input wire logic irq_enable,
  output logic irq_request,
  // Analog core
  input wire logic compare_high,
  output logic sample_hold,
  output logic [11:0] trial_code,
  output logic [3:0] input_channel_field,
  output logic [1:0] reference_level_select,
  output logic bandgap_enable
);

  // --------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------
  sac_pkg::sac_top_state_t s_r;
  sac_pkg::sac_top_state_t s_nxt;
  logic tick;
  logic busy;
  logic done;
  logic [11:0] sar_code;
  logic wr_flag;
  logic wr_start;
  logic start_go;
  logic start_abort;

  assign wr_flag = reg_wr && reg_addr == `SAC_ADDR_INTERRUPT_FLAG_REGISTER;
  assign wr_start = reg_wr && reg_addr == `SAC_ADDR_AUXILIARY_CONTROL_ONE;
  assign start_go = wr_start && reg_wdata[`SAC_START_BIT];
  assign start_abort = wr_start && !reg_wdata[`SAC_START_BIT];

  sac_clk_div u_div (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(busy),
    .div_sel(s_r.div_sel),
    .tick(tick)
  );

  sac_sar_seq u_seq (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(start_go),
    .abort(start_abort),
    .tick(tick),
    .compare_high(compare_high),
    .busy(busy),
    .hold(sample_hold),
    .done(done),
    .sar_code(sar_code)
  );

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        `SAC_ADDR_OPTION: begin
          s_nxt.div_sel = reg_wdata[`SAC_DIV_HI:`SAC_DIV_LO]; // see (R4)
        end
        `SAC_ADDR_INTERRUPT_FLAG_REGISTER: begin
          if (!reg_wdata[`SAC_FLAG_BIT]) begin
            s_nxt.flag = 1'b0; // see (R5)
          end
        end
        `SAC_ADDR_CHAN: begin
          s_nxt.chan = reg_wdata[`SAC_CHAN_HI:`SAC_CHAN_LO]; // see (R7)
        end
        `SAC_ADDR_AUXILIARY_CONTROL_THREE: begin
          s_nxt.bg_en = reg_wdata[`SAC_BG_BIT];
          s_nxt.ref_sel = reg_wdata[`SAC_REF_HI:`SAC_REF_LO]; // see (R9)
        end
        `SAC_ADDR_AUXILIARY_CONTROL_ONE: begin
          s_nxt.start = reg_wdata[`SAC_START_BIT]; // see (R10) (R11)
          if (reg_wdata[`SAC_START_BIT]) begin
            s_nxt.flag = 1'b0; // see (R5)
          end
        end
        default: begin
          s_nxt.start = s_r.start;
        end
      endcase
    end
    // Completion beats a flag clear in the same cycle; a new start keeps the start bit set.
    if (done) begin
      s_nxt.flag = 1'b1; // see (R3)
      s_nxt.result = sar_code; // see (R3) (R14)
      if (!start_go) begin
        s_nxt.start = 1'b0; // see (R10)
      end
    end
    if (reg_rd) begin
      case (reg_addr)
        `SAC_ADDR_OPTION: begin
          s_nxt.rdata[`SAC_DIV_HI:`SAC_DIV_LO] = s_r.div_sel;
        end
        `SAC_ADDR_INTERRUPT_FLAG_REGISTER: begin
          s_nxt.rdata[`SAC_FLAG_BIT] = s_r.flag;
        end
        `SAC_ADDR_DATA_LO: begin
          s_nxt.rdata = {s_r.result[3:0], 4'h0}; // see (R6)
        end
        `SAC_ADDR_DATA_HI: begin
          s_nxt.rdata = s_r.result[11:4]; // see (R6)
        end
        `SAC_ADDR_CHAN: begin
          s_nxt.rdata[`SAC_CHAN_HI:`SAC_CHAN_LO] = s_r.chan;
        end
        `SAC_ADDR_AUXILIARY_CONTROL_THREE: begin
          s_nxt.rdata[`SAC_BG_BIT] = s_r.bg_en;
          s_nxt.rdata[`SAC_REF_HI:`SAC_REF_LO] = s_r.ref_sel;
        end
        `SAC_ADDR_AUXILIARY_CONTROL_ONE: begin
          s_nxt.rdata[`SAC_START_BIT] = s_r.start;
        end
        default: begin
          s_nxt.rdata = 8'h00;
        end
      endcase
    end
    s_nxt.irq = s_nxt.flag && irq_enable; // see (R13)
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.div_sel <= `SAC_DIV_RESET;
      s_r.chan <= `SAC_CHAN_RESET;
      s_r.ref_sel <= `SAC_REF_RESET;
      s_r.result <= `SAC_RES_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign reg_rdata = s_r.rdata;
  assign irq_request = s_r.irq;
  assign trial_code = sar_code;
  assign input_channel_field = s_r.chan;
  assign reference_level_select = s_r.ref_sel;
  assign bandgap_enable = s_r.bg_en;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  AST_FLAG_ON_DONE: assert property (@(posedge clk_sys) disable iff (reset)
    done |=> s_r.flag && s_r.result == $past(sar_code)) // see (R3)
    else $error("done did not set flag and load result");

  AST_START_AUTOCLR: assert property (@(posedge clk_sys)
    disable iff (reset)
    (done && !start_go) |=> !s_r.start) // see (R10)
    else $error("start bit not cleared at end of conversion");

  AST_WRITE_ZERO: assert property (@(posedge clk_sys) disable iff (reset)
    start_abort |=> !s_r.start && !busy) // see (R11)
    else $error("write of zero did not clear start bit");

  AST_FLAG_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_flag && !reg_wdata[`SAC_FLAG_BIT] && !done) |=> !s_r.flag)
    else $error("flag write with bit zero did not clear"); // see (R5)

  AST_IRQ: assert property (@(posedge clk_sys) disable iff (reset)
    (s_r.flag && irq_enable && !done && !wr_flag && !wr_start)
    |=> irq_request) // see (R13)
    else $error("interrupt not raised for set flag");

  AST_RESULT_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    !done |=> $stable(s_r.result)) // see (R14)
    else $error("result changed without a completion");

  AST_READ_HIGH: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_rd && reg_addr == `SAC_ADDR_DATA_HI)
    |=> reg_rdata == $past(s_r.result[11:4])) // see (R6)
    else $error("result high byte read wrong");

  AST_CHAN_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_wr && reg_addr == `SAC_ADDR_CHAN)
    |=> input_channel_field == $past(reg_wdata[3:0])) // see (R7)
    else $error("channel field not written");

  AST_REF_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_wr && reg_addr == `SAC_ADDR_AUXILIARY_CONTROL_THREE)
    |=> reference_level_select == $past(reg_wdata[1:0])) // see (R9)
    else $error("reference field not written");

endmodule : sac_top

// [sim/sac_core_model.sv]
// Behavioural analog core: sample-hold and comparator.
`timescale 1ns/10ps

module sac_core_model (
  // Clock
  input wire logic clk_sys,
  // Converter side
  input wire logic sample_hold,
  input wire logic [11:0] trial_code,
  // Analog level given as a code
  input wire logic [11:0] level,
  // Comparator
  output logic compare_high
);
  logic [11:0] held_r = 12'h000;

  // The input is tracked while sampling and frozen for the bit decisions.
  always @(posedge clk_sys) begin
    if (sample_hold === 1'b1) begin
      held_r <= level;
    end
  end

  assign compare_high = (held_r >= trial_code);
endmodule : sac_core_model

// [sim/sar_adc_conversion_control_bench.sv]
// Self-checking bench of the ADC conversion control.
`timescale 1ns/10ps
`include "sac_defines.svh"

module sar_adc_conversion_control_bench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic irq_enable = 1'b0;
  logic irq_request;
  logic compare_high;
  logic sample_hold;
  logic [11:0] trial_code;
  logic [3:0] chan;
  logic [1:0] vref;
  logic bg_en;
  logic [11:0] level = 12'h000;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  bit [31:0] seed = 32'h53906224;
  int q_res[$];
  int exp_res = 0;

  sac_top i_sac_top (
    .clk_sys(clk_sys),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .irq_enable(irq_enable),
    .irq_request(irq_request),
    .compare_high(compare_high),
    .sample_hold(sample_hold),
    .trial_code(trial_code),
    .input_channel_field(chan),
    .reference_level_select(vref),
    .bandgap_enable(bg_en)
  );

  sac_core_model i_sac_core_model (
    .clk_sys(clk_sys),
    .sample_hold(sample_hold),
    .trial_code(trial_code),
    .level(level),
    .compare_high(compare_high)
  );

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  function automatic bit [31:0] xs(input bit [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      mismatches++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                       input string m);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata === e, m);
  endtask : rdchk

  // The model queue holds the level that each conversion started by start_conv sees.
  task automatic start_conv();
    seed = xs(seed);
    level <= seed[11:0];
    q_res.push_back(seed[11:0]);
    wr(`SAC_ADDR_AUXILIARY_CONTROL_ONE, 8'h10);
  endtask : start_conv

  task automatic wait_done(input int n, output int t, output int sh);
    t = 0;
    sh = 0;
    while (irq_request !== 1'b1 && t < 60 * n) begin
      @(posedge clk_sys);
      #1;
      t++;
      if (sample_hold === 1'b1) sh++;
    end
  endtask : wait_done

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int n;
    int t;
    int sh;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rdchk(`SAC_ADDR_OPTION, 8'h00, "option reset");
    rdchk(`SAC_ADDR_INTERRUPT_FLAG_REGISTER, 8'h00, "flag reset");
    rdchk(`SAC_ADDR_CHAN, 8'h0f, "channel reset");
    rdchk(`SAC_ADDR_AUXILIARY_CONTROL_ONE, 8'h00, "start reset");
    rdchk(8'h00, 8'h00, "unmapped read");
    chk(chan === 4'hf, "channel pins reset");
    $display("test reset done");
    irq_enable <= 1'b1;
    for (int dv = 0; dv < 4; dv++) begin
      n = 32 >> dv;
      seed = xs(seed);
      wr(`SAC_ADDR_OPTION, 8'(dv << 2));
      wr(`SAC_ADDR_CHAN, {4'h0, seed[15:12]});
      wr(`SAC_ADDR_AUXILIARY_CONTROL_THREE, {6'h00, 2'(dv)});
      rdchk(`SAC_ADDR_OPTION, 8'(dv << 2), "divider readback");
      chk(chan === seed[15:12], "channel pins");
      chk(vref === 2'(dv) && bg_en === 1'b0, "reference pins");
      start_conv();
      wait_done(n, t, sh);
      exp_res = q_res.pop_front();
      chk(t >= 50 * n && t <= 50 * n + 4, "conversion time");
      chk(sh >= 26 * n - 1 && sh <= 26 * n + 2, "sample time");
      rdchk(`SAC_ADDR_INTERRUPT_FLAG_REGISTER, 8'h10, "done flag");
      rdchk(`SAC_ADDR_AUXILIARY_CONTROL_ONE, 8'h00, "start self clear");
      rdchk(`SAC_ADDR_DATA_HI, 8'(exp_res >> 4), "result high");
      rdchk(`SAC_ADDR_DATA_LO, 8'((exp_res & 15) << 4), "result low");
      wr(`SAC_ADDR_INTERRUPT_FLAG_REGISTER, 8'hef);
      rdchk(`SAC_ADDR_INTERRUPT_FLAG_REGISTER, 8'h00, "flag write clear");
      $display("test divider %0d done", n);
    end
    irq_enable <= 1'b0;
    start_conv();
    repeat (260) @(posedge clk_sys);
    #1;
    exp_res = q_res.pop_front();
    chk(irq_request === 1'b0, "masked request");
    rdchk(`SAC_ADDR_INTERRUPT_FLAG_REGISTER, 8'h10, "flag while masked");
    irq_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(irq_request === 1'b1, "unmasked request");
    wr(`SAC_ADDR_AUXILIARY_CONTROL_ONE, 8'h10);
    rdchk(`SAC_ADDR_INTERRUPT_FLAG_REGISTER, 8'h00, "start clears flag");
    wr(`SAC_ADDR_AUXILIARY_CONTROL_ONE, 8'h00);
    rdchk(`SAC_ADDR_AUXILIARY_CONTROL_ONE, 8'h00, "zero write clears start");
    repeat (260) @(posedge clk_sys);
    rdchk(`SAC_ADDR_INTERRUPT_FLAG_REGISTER, 8'h00, "no flag after abort");
    rdchk(`SAC_ADDR_DATA_HI, 8'(exp_res >> 4), "result held");
    $display("test interrupt and abort done");
    wr(`SAC_ADDR_AUXILIARY_CONTROL_THREE, 8'h07);
    rdchk(`SAC_ADDR_AUXILIARY_CONTROL_THREE, 8'h07, "aux readback");
    chk(bg_en === 1'b1 && vref === 2'h3, "bandgap pins");
    wr(`SAC_ADDR_AUXILIARY_CONTROL_THREE, 8'h00);
    wr(`SAC_ADDR_CHAN, 8'h0f);
    rdchk(`SAC_ADDR_CHAN, 8'h0f, "idle channel");
    chk(bg_en === 1'b0 && chan === 4'hf, "idle pins");
    $display("test idle setting done");
    report_and_stop();
  end
endmodule : sar_adc_conversion_control_bench
